// >>> src/usb_interrupt_flags.sv
// usb interrupt flag register with enables, error summary and token status fifo
//
// Contract
// RULE1 - hardware sets flags; write one clears
// RULE2 - stall flag on stall seen or sent
// RULE3 - attach needs host, 2.5us quiet, no se0
// RULE4 - resume flag after 2.5us of k-state
// RULE5 - software disables resume outside suspend
// RULE6 - idle flag after 3ms continuous idle
// RULE7 - token flag; status shows endpoint info
// RULE8 - clearing token flag advances status fifo
// RULE9 - sof flag: token received or threshold
// RULE10 - error summary read-only, only enabled errors
// RULE11 - bit zero: reset or detach by mode
// RULE12 - upper bits read zero, ignore writes
// RULE13 - flags reset zero; irq when enabled flag
`default_nettype none
module usb_interrupt_flags #(
  parameter int idle_count = usb_flags_pkg::idle_cycles,
  parameter int depth      = usb_flags_pkg::stat_depth
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_b_in,
  input  wire usb_flags_pkg::bus_req_type    bus_in,
  input  wire usb_flags_pkg::usb_event_type  event_in,
  input  wire usb_flags_pkg::line_state_type line_in,
  input  wire logic [7:0]                    error_in,
  output logic [31:0]                        rdata_out,
  output logic                               irq_out,
  output logic                               host_mode_out
);
  import usb_flags_pkg::*;

  localparam int qw = $clog2(quiet_cycles + 1);
  localparam int iw = $clog2(idle_count + 1);
  localparam int pw = $clog2(depth);

  logic [7:0]    flags_q;
  logic [7:0]    enable_q;
  logic [7:0]    err_enable_q;
  logic          host_en_q;
  logic [qw-1:0] quiet_cnt_q;
  logic [qw-1:0] k_cnt_q;
  logic [iw-1:0] idle_cnt_q;
  logic          k_seen_q;
  logic          idle_seen_q;
  logic [7:0]    stat_mem [depth];
  logic [pw-1:0] wr_ptr_q;
  logic [pw-1:0] rd_ptr_q;
  logic [pw:0]   count_q;
  logic [7:0]    set_vec;
  logic [7:0]    wr_clear;
  logic          wr_flags;
  logic          rd_any;
  logic          attach_ok;
  logic          pop;
  logic          push;

  function automatic logic [qw-1:0] sat_inc(input logic [qw-1:0] v);
    sat_inc = (v == qw'(quiet_cycles)) ? v : v + qw'(1);
  endfunction : sat_inc

  assign wr_flags = bus_in.wr && (bus_in.addr == flags_offset);
  assign rd_any   = bus_in.rd;
  // only flag bits may be cleared; the error summary is derived
  assign wr_clear = wr_flags ? (bus_in.wdata[7:0] & clear_mask) : 8'h00; // [RULE1] [RULE12]

  // bus quiet and k-state timers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      quiet_cnt_q <= '0;
      k_cnt_q     <= '0;
    end else begin
      quiet_cnt_q <= line_in.activity ? '0 : sat_inc(quiet_cnt_q);
      k_cnt_q     <= line_in.k_state ? sat_inc(k_cnt_q) : '0;
    end
  end

  // a line that is busy in this very cycle is not quiet, whatever the counter holds
  assign attach_ok = host_en_q && (quiet_cnt_q == qw'(quiet_cycles))
                     && !line_in.se0 && !line_in.activity; // [RULE3]

  // idle timer; the flag fires once per continuous idle stretch
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idle_cnt_q  <= '0;
      idle_seen_q <= 1'b0;
      k_seen_q    <= 1'b0;
    end else begin
      if (!line_in.idle_state) begin
        idle_cnt_q  <= '0;
        idle_seen_q <= 1'b0;
      end else if (idle_cnt_q != iw'(idle_count)) begin
        idle_cnt_q <= idle_cnt_q + iw'(1);
      end else begin
        idle_seen_q <= 1'b1;
      end
      k_seen_q <= (k_cnt_q == qw'(quiet_cycles));
    end
  end

  always_comb begin
    set_vec = 8'h00;
    set_vec[stall_bit]  = host_en_q ? event_in.stall_rx : event_in.stall_tx; // [RULE2]
    set_vec[attach_bit] = attach_ok; // [RULE3]
    set_vec[resume_bit] = (k_cnt_q == qw'(quiet_cycles)) && !k_seen_q; // [RULE4]
    set_vec[idle_bit]   = line_in.idle_state && !idle_seen_q
                          && (idle_cnt_q == iw'(idle_count)); // [RULE6]
    set_vec[token_bit]  = event_in.token_done; // [RULE7]
    set_vec[sof_bit]    = host_en_q ? event_in.sof_threshold : event_in.sof_rx; // [RULE9]
    set_vec[reset_bit]  = host_en_q ? event_in.detach : event_in.bus_reset; // [RULE11]
  end

  // set wins over a simultaneous write-one clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags_q <= flags_reset; // [RULE13]
    end else begin
      flags_q <= (flags_q & ~wr_clear) | set_vec; // [RULE1]
      // token flag stays up while more statuses wait behind the head
      if (pop && count_q > (pw+1)'(1)) begin
        flags_q[token_bit] <= 1'b1; // [RULE8]
      end
      flags_q[error_bit] <= 1'b0;
    end
  end

  // status fifo; a full fifo drops the newest status
  assign push = event_in.token_done && (count_q != (pw+1)'(depth));
  assign pop  = wr_clear[token_bit] && flags_q[token_bit] && (count_q != '0); // [RULE8]

  always_ff @(posedge clk_in) begin
    if (push) begin
      stat_mem[wr_ptr_q] <= event_in.token_status;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + pw'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + pw'(1); // [RULE8]
      end
      count_q <= count_q + (pw+1)'(push) - (pw+1)'(pop);
    end
  end

  // control registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      enable_q     <= 8'h00;
      err_enable_q <= 8'h00;
      host_en_q    <= 1'b0;
    end else if (bus_in.wr) begin
      case (bus_in.addr)
        enable_offset:     enable_q     <= bus_in.wdata[7:0];
        err_enable_offset: err_enable_q <= bus_in.wdata[7:0];
        control_offset:    host_en_q    <= bus_in.wdata[0];
        default:           ;
      endcase
    end
  end

  logic [7:0] flags_view;
  logic       err_summary;
  logic [7:0] stat_head;
  // masked errors never reach the summary bit
  assign err_summary = |(error_in & err_enable_q); // [RULE10]
  // an empty fifo reads zero instead of a stale entry
  assign stat_head = (count_q != '0) ? stat_mem[rd_ptr_q] : 8'h00; // [RULE7]
  always_comb begin
    flags_view = flags_q;
    flags_view[error_bit] = err_summary; // [RULE10]
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_any) begin
      case (bus_in.addr)
        flags_offset:      rdata_out <= {24'h00_0000, flags_view}; // [RULE12]
        enable_offset:     rdata_out <= {24'h00_0000, enable_q};
        err_enable_offset: rdata_out <= {24'h00_0000, err_enable_q};
        status_offset:     rdata_out <= {24'h00_0000, stat_head}; // [RULE7]
        control_offset:    rdata_out <= {31'h0000_0000, host_en_q};
        default:           rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  // resume enable left to software; suspend state is not tracked here [RULE5]
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out       <= 1'b0;
      host_mode_out <= 1'b0;
    end else begin
      irq_out       <= |(flags_view & enable_q); // [RULE13]
      host_mode_out <= host_en_q;
    end
  end

  // single-cycle conditions, spelled out once
  sequence k_run_done_seq;
    (k_cnt_q == qw'(quiet_cycles)) && !k_seen_q;
  endsequence
  sequence pop_more_seq;
    pop && (count_q > (pw+1)'(1));
  endsequence
  sequence read_flags_seq;
    bus_in.rd && (bus_in.addr == flags_offset);
  endsequence

  // write-one clears, write-zero keeps
  chk_clear_write_one: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE1]
    wr_flags && bus_in.wdata[stall_bit] && !set_vec[stall_bit] |=> !flags_q[stall_bit])
    else $error("stall flag not cleared by write one");
  chk_clear_keep_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE1]
    wr_flags && !bus_in.wdata[sof_bit] && flags_q[sof_bit] |=> flags_q[sof_bit])
    else $error("write zero cleared sof flag");

  // start-of-frame by mode
  chk_set_wins_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE9]
    set_vec[sof_bit] |=> flags_q[sof_bit])
    else $error("sof event lost");
  chk_sof_device: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE9]
    !host_en_q && event_in.sof_rx |=> flags_q[sof_bit])
    else $error("sof token not flagged");

  // stall handshake by mode
  chk_stall_mode: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE2]
    !host_en_q && event_in.stall_tx |=> flags_q[stall_bit])
    else $error("stall sent not flagged");
  chk_stall_host: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE2]
    host_en_q && event_in.stall_rx |=> flags_q[stall_bit])
    else $error("stall received not flagged");

  // attach qualification
  chk_attach_host: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE3]
    !host_en_q |-> !set_vec[attach_bit])
    else $error("attach flagged outside host mode");
  chk_attach_quiet: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE3]
    line_in.activity |=> !set_vec[attach_bit])
    else $error("attach flagged without quiet time");
  chk_attach_busy: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE3]
    line_in.activity || line_in.se0 |-> !set_vec[attach_bit])
    else $error("attach flagged on busy or se0 line");

  // resume after a long k-state
  chk_resume_k: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE4]
    $rose(set_vec[resume_bit]) |-> $past(line_in.k_state))
    else $error("resume without k state");
  chk_resume_set: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE4]
    k_run_done_seq |=> flags_q[resume_bit] && !set_vec[resume_bit])
    else $error("resume not flagged once");

  // idle detect fires once per stretch
  chk_idle_flag: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE6]
    set_vec[idle_bit] |-> line_in.idle_state && idle_cnt_q == iw'(idle_count))
    else $error("idle flag early");
  chk_idle_once: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE6]
    set_vec[idle_bit] |=> flags_q[idle_bit] && !set_vec[idle_bit])
    else $error("idle flag repeated");

  // token completion and status fifo
  chk_token_set: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE7]
    event_in.token_done |=> flags_q[token_bit])
    else $error("token completion not flagged");
  chk_token_pop: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE8]
    pop && !push |=> count_q == $past(count_q) - (pw+1)'(1))
    else $error("status fifo not advanced");
  chk_token_push: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE8]
    push && !pop |=> count_q == $past(count_q) + (pw+1)'(1))
    else $error("status fifo not filled");
  chk_token_refill: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE8]
    pop_more_seq |=> flags_q[token_bit])
    else $error("token flag lost with status waiting");

  // error summary
  chk_error_mask: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE10]
    (error_in & err_enable_q) == 8'h00 |-> !flags_view[error_bit])
    else $error("masked error set summary");
  chk_error_ro: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE10]
    wr_flags |-> !wr_clear[error_bit])
    else $error("error summary cleared by write");

  // bit zero by mode
  chk_bit0_mode: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE11]
    host_en_q && event_in.detach |=> flags_q[reset_bit])
    else $error("detach not flagged");
  chk_bit0_device: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE11]
    !host_en_q && event_in.bus_reset |=> flags_q[reset_bit])
    else $error("bus reset not flagged");

  // unused upper bits
  chk_upper_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE12]
    read_flags_seq |=> rdata_out[31:8] == 24'h00_0000)
    else $error("upper flag bits not zero");

  // interrupt request level
  chk_irq_level: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE13]
    (flags_view & enable_q) != 8'h00 |=> irq_out)
    else $error("irq not raised");
  chk_irq_drop: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RULE13]
    (flags_view & enable_q) == 8'h00 |=> !irq_out)
    else $error("irq raised without enabled flag");
endmodule : usb_interrupt_flags
`default_nettype wire

// >>> src/usb_flags_pkg.sv
// package: register map, field positions and timing constants of the usb interrupt flag block
`default_nettype none
package usb_flags_pkg;
  localparam logic [7:0] flags_offset      = 8'h00;
  localparam logic [7:0] enable_offset     = 8'h04;
  localparam logic [7:0] err_enable_offset = 8'h08;
  localparam logic [7:0] status_offset     = 8'h0C;
  localparam logic [7:0] control_offset    = 8'h10;
  localparam int stall_bit  = 7;
  localparam int attach_bit = 6;
  localparam int resume_bit = 5;
  localparam int idle_bit   = 4;
  localparam int token_bit  = 3;
  localparam int sof_bit    = 2;
  localparam int error_bit  = 1;
  localparam int reset_bit  = 0;
  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [7:0] clear_mask  = 8'hFD;
  localparam int clk_mhz          = 200;
  localparam int quiet_time_ns    = 2500;
  localparam int idle_time_us     = 3000;
  localparam int quiet_cycles     = (quiet_time_ns * clk_mhz + 999) / 1000;
  localparam int idle_cycles      = idle_time_us * clk_mhz;
  localparam int stat_depth       = 4;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;
  typedef struct packed {
    logic stall_rx;
    logic stall_tx;
    logic sof_rx;
    logic sof_threshold;
    logic bus_reset;
    logic detach;
    logic token_done;
    logic [7:0] token_status;
  } usb_event_type;
  typedef struct packed {
    logic k_state;
    logic se0;
    logic idle_state;
    logic activity;
  } line_state_type;
endpackage : usb_flags_pkg
`default_nettype wire

// >>> test/usb_bus_model.sv
// far-side usb bus model: line levels and one-cycle protocol event pulses
`default_nettype none
module usb_bus_model
  import usb_flags_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           go_in,
  input  wire logic [2:0]     kind_in,
  input  wire logic [7:0]     status_in,
  input  wire line_state_type line_cmd_in,
  output var usb_event_type   event_out,
  output var line_state_type  line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk_q = 8'h5a;
  // status lines carry a moving pattern between tokens, never a stale value
  always_ff @(posedge clk_in) begin
    junk_q <= junk_q + 8'h35;
  end
  // kind order: stall_rx, stall_tx, sof_rx, sof_threshold, bus_reset, detach, token_done
  always_ff @(posedge clk_in) begin
    event_out <= {(go_in ? 7'(7'h40 >> kind_in) : 7'h00),
                  ((go_in && kind_in == 3'd6) ? status_in : junk_q)};
  end
  always_ff @(posedge clk_in) begin
    line_out <= line_cmd_in;
  end
endmodule : usb_bus_model
`default_nettype wire

// >>> test/tb.sv
// testbench: register-level checks of the usb interrupt flag block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_flags_pkg::*;
  logic           clk_in   = 1'b0;
  logic           rst_b_in = 1'b0;
  bus_req_type    req      = '0;
  line_state_type lcmd     = 4'b0001;
  logic [7:0]     err      = 8'h00;
  logic           go       = 1'b0;
  logic [2:0]     kind     = 3'd0;
  logic [7:0]     stat     = 8'h00;
  logic [31:0]    seed     = 32'hab3a;
  logic           rd_q     = 1'b0;
  usb_event_type  ev_w;
  line_state_type line_w;
  logic [31:0]    rdata_w;
  logic           irq_w;
  logic           host_w;
  logic [31:0]    expq[$];
  int             miscompares  = 0;
  int             total_checks = 0;
  always #2.5 clk_in = ~clk_in;
  usb_interrupt_flags #(.idle_count(20)) usb_interrupt_flags_inst (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .bus_in(req), .event_in(ev_w), .line_in(line_w), .error_in(err),
    .rdata_out(rdata_w), .irq_out(irq_w), .host_mode_out(host_w));
  usb_bus_model usb_bus_model_inst (.clk_in(clk_in), .go_in(go), .kind_in(kind),
    .status_in(stat), .line_cmd_in(lcmd), .event_out(ev_w), .line_out(line_w));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    expq.push_back(e);
    @(posedge clk_in);
    req.rd <= 1'b0;
    @(posedge clk_in);
  endtask : rd
  task automatic pulse(input logic [2:0] k, input logic [7:0] s);
    kind <= k;
    stat <= s;
    go   <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : pulse
  task automatic hold(input line_state_type l, input int n);
    lcmd <= l;
    repeat (n) @(posedge clk_in);
    lcmd <= 4'b0001;
    repeat (3) @(posedge clk_in);
  endtask : hold
  task automatic summarize;
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // read data stand only in the cycle after the strobe
  always @(posedge clk_in) rd_q <= req.rd;
  always @(negedge clk_in) begin
    if (rd_q && expq.size() > 0) chk(rdata_w, expq.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    rd(flags_offset, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    // only the events of the current mode may set flags
    for (int k = 0; k < 6; k++) pulse(k[2:0], 8'h00);
    rd(flags_offset, 32'h0000_0085);
    wr(flags_offset, 32'h0000_0001);
    rd(flags_offset, 32'h0000_0084);
    wr(flags_offset, 32'hFFFF_FF05);
    rd(flags_offset, 32'h0000_0080);
    wr(flags_offset, 32'h0000_0000);
    rd(flags_offset, 32'h0000_0080);
    wr(enable_offset, 32'h0000_0080);  // resume enable stays off
    rd(enable_offset, 32'h0000_0080);
    chk({31'h0, irq_w}, 32'h1);
    wr(flags_offset, 32'h0000_00FF);
    // irq is registered: look one edge after the clear has reached it
    @(posedge clk_in);
    chk({31'h0, irq_w}, 32'h0);
    wr(control_offset, 32'h0000_0001);
    rd(control_offset, 32'h0000_0001);
    chk({31'h0, host_w}, 32'h1);
    for (int k = 0; k < 6; k++) pulse(k[2:0], 8'h00);
    rd(flags_offset, 32'h0000_0085);
    wr(flags_offset, 32'h0000_00FF);
    hold(4'b0100, 510);
    rd(flags_offset, 32'h0000_0000);
    hold(4'b0000, 510);
    rd(flags_offset, 32'h0000_0040);
    wr(flags_offset, 32'h0000_0040);
    wr(control_offset, 32'h0000_0000);
    hold(4'b1001, 510);
    rd(flags_offset, 32'h0000_0020);
    hold(4'b0011, 10);
    rd(flags_offset, 32'h0000_0020);
    hold(4'b0011, 30);
    rd(flags_offset, 32'h0000_0030);
    wr(flags_offset, 32'h0000_0030);
    pulse(3'd6, 8'h3C);
    pulse(3'd6, 8'hA5);
    rd(flags_offset, 32'h0000_0008);
    rd(status_offset, 32'h0000_003C);
    wr(flags_offset, 32'h0000_0008);
    rd(flags_offset, 32'h0000_0008);
    rd(status_offset, 32'h0000_00A5);
    wr(flags_offset, 32'h0000_0008);
    rd(flags_offset, 32'h0000_0000);
    rd(status_offset, 32'h0000_0000);
    pulse(3'd1, 8'h00);
    rd(flags_offset, 32'h0000_0080);
    // a second reset in mid-run must wipe flags and control state
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    rd(flags_offset, 32'h0000_0000);
    rd(enable_offset, 32'h0000_0000);
    wr(err_enable_offset, 32'h0000_000F);
    rd(err_enable_offset, 32'h0000_000F);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      err <= seed[7:0];
      repeat (2) @(posedge clk_in);
      wr(flags_offset, 32'h0000_0002);
      rd(flags_offset, {30'h0, |seed[3:0], 1'b0});
    end
    summarize();
  end
endmodule : tb
`default_nettype wire
